// ---- tpo_far_end.sv ----
// Purpose: Far-end timing receiver on the pulse and strobe pins
// Assumes: Bench sets the level it drives onto the strobe pin
// Notes: Counts pulse rises it sees on the general-purpose pin
module tpo_far_end (
  // Clock
  input wire logic clk_i,
  // Device pins
  input wire logic pps_i,
  input wire logic pin_drv_i,
  input wire logic pin_oe_n_i,
  // Bench level for the strobe pin
  input wire logic lvl_i,
  // Resolved pin and pulse count
  output logic pin_o,
  output logic [7:0] rises_o
);
  // ==========================================================
  // Pin resolution and pulse count
  // ==========================================================
  logic pps_q;
  logic [7:0] cnt = 8'h00;
  // Device owns the pin while its enable is low
  assign pin_o = pin_oe_n_i ? lvl_i : pin_drv_i;
  assign rises_o = cnt;
  always @(posedge clk_i)
  begin
    pps_q <= pps_i;
    if (pps_i && !pps_q)
      cnt <= cnt + 8'h01;
  end
endmodule : tpo_far_end

// ---- tpo_gen.sv ----
// Purpose: Time counter and pulse output generator, engine A
// Assumes: Inputs synchronous to clk_i, engine B lives outside
// Notes: Normal pulse lags threshold crossing by one clock
//
// Functional notes
// - Pulse asserts when counter passes threshold
// - Zero threshold gives pulse each second
// - Pulse width from setting, routed to GPIO
// - Alternate mode drives output from counter bit
// - Bit 4 to 8, period power of two
// - Alternate edges follow counter increment
// - Synthesizer toggles with high/low durations
// - Clearing synthesizer enable restores pulse output
// - Nanosecond resolution at every clock rate
// - Counter runs at four supported clock rates
// - Five separately enabled high-resolution units
// - Raw strobe looped straight to pulse output
// - Strobe pin driven around pulse assertion
// - Pulse output fed back into strobe path
// - Page four exposes window registers 16-18
// - High half reg 18, low 17, command 16
// - Ports 0,2 engine A; 1,3 engine B
module tpo_gen
  import tpo_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Counter clock rate select
  input wire logic [1:0] ltc_rate_i,
  // Management access
  input wire logic mgmt_we_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic [1:0] mgmt_port_i,
  output logic [15:0] mgmt_rdata_o,
  // Engine B command path
  output logic eng_b_valid_o,
  output logic eng_b_write_o,
  output logic [2:0] eng_b_idx_o,
  output logic [31:0] eng_b_wdata_o,
  input wire logic [31:0] eng_b_rdata_i,
  // Pulse outputs
  output logic pps_o,
  output logic gpio_pps_o,
  // Strobe pin
  input wire logic strobe_i,
  output logic strobe_out_o,
  output logic strobe_oe_n_o,
  output logic strobe_sync_o,
  // Status and configuration
  output logic [NS_W-1:0] ltc_ns_o,
  output logic [SEC_W-1:0] ltc_sec_o,
  output logic [4:0] hires_en_o,
  output logic ext_clk_sel_o
);

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [INC_W-1:0] inc_of(input logic [1:0] rate);
    logic [INC_W-1:0] v;
    unique case (rate)
      RATE_125: v = INC_125;
      RATE_156: v = INC_156;
      RATE_200: v = INC_200;
      default: v = INC_250;
    endcase
    return v;
  endfunction : inc_of

  // Threshold inside (old, new], across the second wrap too
  function automatic logic crossed(input logic [FX_W-1:0] old_v,
                                   input logic [FX_W-1:0] new_v,
                                   input logic wrap,
                                   input logic [FX_W-1:0] th);
    logic r;
    if (wrap)
      r = (th > old_v) || (th <= new_v);
    else
      r = (th > old_v) && (th <= new_v);
    return r;
  endfunction : crossed

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [FX_W-1:0] ns_fx;
    logic [SEC_W-1:0] sec;
    logic [31:0] thresh;
    logic [31:0] width;
    logic [7:0] ctrl;
    logic [31:0] syn_hi;
    logic [31:0] syn_lo;
    logic [4:0] hires;
    tpo_pstate_t pst;
    logic [39:0] wcnt;
    logic [1:0] oe_cnt;
    logic pps;
    logic sync1;
    logic sync2;
  } tpo_gen_t;

  tpo_gen_t s_r;
  tpo_gen_t s_nxt;
  tpo_mgmt_if m ();
  logic [INC_W-1:0] inc;
  logic [FX_W:0] ns_sum;
  logic wrap;
  logic hit;
  logic [FX_W-1:0] th_fx;
  logic [39:0] width_fx;
  logic [39:0] wcnt_n;
  logic [2:0] alt_sel;
  logic [31:0] local_rd;
  logic syn_out;
  logic strobe_path;

  // ==========================================================
  // Submodules
  // ==========================================================
  tpo_window u_window (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .mgmt_we_i(mgmt_we_i),
    .mgmt_addr_i(mgmt_addr_i),
    .mgmt_wdata_i(mgmt_wdata_i),
    .mgmt_port_i(mgmt_port_i),
    .mgmt_rdata_o(mgmt_rdata_o),
    .ext_clk_sel_o(ext_clk_sel_o),
    .m(m.win)
  );

  tpo_synth u_synth (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(s_r.ctrl[CB_SYN_EN]),
    .inc_i(inc),
    .hi_ns_i(s_r.syn_hi),
    .lo_ns_i(s_r.syn_lo),
    .out_o(syn_out)
  );

  // ==========================================================
  // Engine A register reads, engine B forwarding
  // ==========================================================
  always_comb
  begin
    unique case (m.idx)
      TR_THRESH: local_rd = s_r.thresh;
      TR_WIDTH: local_rd = s_r.width;
      TR_CTRL: local_rd = {24'h00_0000, s_r.ctrl};
      TR_SYN_HI: local_rd = s_r.syn_hi;
      TR_SYN_LO: local_rd = s_r.syn_lo;
      TR_HIRES: local_rd = {27'h000_0000, s_r.hires};
      TR_NS: local_rd = {2'b00, s_r.ns_fx[FX_W-1:FRAC_W]};
      default: local_rd = s_r.sec[31:0];
    endcase
  end

  // Engine B answers in the same cycle, like engine A
  assign m.rdata = m.eng_b ? eng_b_rdata_i : local_rd;
  assign eng_b_valid_o = m.valid & m.eng_b;
  assign eng_b_write_o = m.write;
  assign eng_b_idx_o = m.idx;
  assign eng_b_wdata_o = m.wdata;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    s_nxt = s_r;
    inc = inc_of(ltc_rate_i);

    // Fractional accumulation keeps 1 ns resolution at any rate
    ns_sum = {1'b0, s_r.ns_fx} + {27'h000_0000, inc};
    wrap = (ns_sum >= {1'b0, NS_WRAP_FX});
    if (wrap)
    begin
      s_nxt.ns_fx = FX_W'(ns_sum - {1'b0, NS_WRAP_FX});
      s_nxt.sec = s_r.sec + 48'h0000_0000_0001;
    end
    else
    begin
      s_nxt.ns_fx = ns_sum[FX_W-1:0];
    end

    // Threshold 0 fires on the wrap itself
    th_fx = {s_r.thresh[NS_W-1:0], FRAC_ZERO};
    hit = crossed(s_r.ns_fx, s_nxt.ns_fx, wrap, th_fx);
    width_fx = {2'b00, s_r.width[NS_W-1:0], FRAC_ZERO};
    wcnt_n = s_r.wcnt + {28'h000_0000, inc};

    // Strobe drive window counts down independently
    if (s_r.oe_cnt != 2'h0)
      s_nxt.oe_cnt = s_r.oe_cnt - 2'h1;

    unique case (s_r.pst)
      TPO_IDLE:
      begin
        // Zero width means no pulse at all
        if (hit && (s_r.width != 32'h0000_0000))
        begin
          s_nxt.pst = TPO_ARMED;
          s_nxt.oe_cnt = STROBE_OE_LEN;
        end
      end
      TPO_ARMED:
      begin
        s_nxt.pst = TPO_HIGH;
        s_nxt.wcnt = 40'h00_0000_0000;
      end
      TPO_HIGH:
      begin
        // Crossings during a pulse are dropped
        if (wcnt_n >= width_fx)
          s_nxt.pst = TPO_IDLE;
        else
          s_nxt.wcnt = wcnt_n;
      end
      default:
      begin
        s_nxt.pst = TPO_IDLE;
      end
    endcase

    // Alternate mode: counter bit, width ignored
    alt_sel = (s_r.ctrl[CB_ALT_SEL +: 3] > ALT_SEL_MAX) ?
              ALT_SEL_MAX : s_r.ctrl[CB_ALT_SEL +: 3];
    if (s_r.ctrl[CB_ALT_EN])
      s_nxt.pps = s_nxt.ns_fx[FRAC_W + ALT_BIT_BASE + 32'(alt_sel)];
    else
      s_nxt.pps = (s_nxt.pst == TPO_HIGH);

    // Engine A register writes
    if (m.valid && !m.eng_b && m.write)
    begin
      unique case (m.idx)
        TR_THRESH: s_nxt.thresh = m.wdata;
        TR_WIDTH: s_nxt.width = m.wdata;
        TR_CTRL: s_nxt.ctrl = m.wdata[7:0];
        TR_SYN_HI: s_nxt.syn_hi = m.wdata;
        TR_SYN_LO: s_nxt.syn_lo = m.wdata;
        TR_HIRES: s_nxt.hires = m.wdata[4:0];
        default: ;
      endcase
    end

    // Two-stage synchronizer on the strobe input path
    s_nxt.sync1 = strobe_path;
    s_nxt.sync2 = s_r.sync1;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
      s_r.thresh <= THRESH_RST;
      s_r.width <= WIDTH_RST;
      s_r.ctrl <= CTRL_RST;
      s_r.syn_hi <= SYN_RST;
      s_r.syn_lo <= SYN_RST;
      s_r.hires <= HIRES_RST;
      s_r.pst <= TPO_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Output selection and loopbacks
  // ==========================================================
  // Raw strobe bypasses all flops, for pin-to-pin delay measurement
  always_comb
  begin
    if (s_r.ctrl[CB_S2P])
      pps_o = strobe_i;
    else if (s_r.ctrl[CB_SYN_EN])
      pps_o = syn_out;
    else
      pps_o = s_r.pps;
  end

  assign gpio_pps_o = pps_o;

  // Tap taken at the output mux so generation delay is included
  assign strobe_path = s_r.ctrl[CB_P2S] ? pps_o : strobe_i;
  assign strobe_sync_o = s_r.sync2;

  // Enable leads pulse by one clock, held two more
  assign strobe_oe_n_o = ~(s_r.ctrl[CB_PIN] &&
                           (s_r.oe_cnt != 2'h0));
  assign strobe_out_o = s_r.pps;

  assign ltc_ns_o = s_r.ns_fx[FX_W-1:FRAC_W];
  assign ltc_sec_o = s_r.sec;
  assign hires_en_o = s_r.hires;

endmodule : tpo_gen

// ---- tpo_gen_bench.sv ----
// Purpose: Self-checking bench of the pulse output generator
// Assumes: Counter far from its second wrap during the run
// Notes: Whole-second pulses are out of reach of a short run
`define CHK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) \
    begin \
      bad_count++; \
      $display("wrong value %s exp %0h seen %0h", nm, ex, got); \
    end \
  end
module tpo_gen_bench
  import tpo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals, clock, instances
  // ==========================================================
  logic clk_i, rst_n_i, mgmt_we_i, eng_b_valid_o, eng_b_write_o, pps_o;
  logic gpio_pps_o, strobe_i, strobe_out_o, strobe_oe_n_o, strobe_sync_o;
  logic ext_clk_sel_o, lvl, pq, oq, oe_pre;
  logic [1:0] ltc_rate_i, mgmt_port_i;
  logic [2:0] eng_b_idx_o;
  logic [4:0] mgmt_addr_i, hires_en_o;
  logic [15:0] mgmt_wdata_i, mgmt_rdata_o;
  logic [31:0] eng_b_wdata_o, eng_b_rdata_i, v;
  logic [35:0] last_b;
  logic [NS_W-1:0] ltc_ns_o, t0;
  logic [SEC_W-1:0] ltc_sec_o;
  logic [7:0] rises;
  int bad_count, n_tests, cyc, n, m, oe_lo;
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  tpo_gen uut (
    .clk_i, .rst_n_i, .ltc_rate_i, .mgmt_we_i, .mgmt_addr_i,
    .mgmt_wdata_i, .mgmt_port_i, .mgmt_rdata_o, .eng_b_valid_o,
    .eng_b_write_o, .eng_b_idx_o, .eng_b_wdata_o, .eng_b_rdata_i,
    .pps_o, .gpio_pps_o, .strobe_i, .strobe_out_o, .strobe_oe_n_o,
    .strobe_sync_o, .ltc_ns_o, .ltc_sec_o, .hires_en_o, .ext_clk_sel_o
  );
  tpo_far_end far (.clk_i(clk_i), .pps_i(gpio_pps_o),
    .pin_drv_i(strobe_out_o), .pin_oe_n_i(strobe_oe_n_o),
    .lvl_i(lvl), .pin_o(strobe_i), .rises_o(rises));
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      wrap_up();
    end
    pq <= pps_o;
    oq <= strobe_oe_n_o;
    if (pps_o && !pq)
      oe_pre <= !oq;
    if (!strobe_oe_n_o)
      oe_lo <= oe_lo + 1;
    if (eng_b_valid_o)
      last_b <= {eng_b_write_o, eng_b_idx_o, eng_b_wdata_o};
  end
  // ==========================================================
  // Management access
  // ==========================================================
  task automatic mw(input logic [4:0] a, input logic [15:0] d,
                    input logic [1:0] p = 2'h0);
    @(posedge clk_i);
    mgmt_we_i <= 1'b1;
    mgmt_addr_i <= a;
    mgmt_wdata_i <= d;
    mgmt_port_i <= p;
    @(posedge clk_i);
    mgmt_we_i <= 1'b0;
  endtask : mw
  task automatic mr(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    mgmt_addr_i <= a;
    repeat (2) @(posedge clk_i);
    #1 d = mgmt_rdata_o;
  endtask : mr
  task automatic tw(input logic [2:0] i, input logic [31:0] d,
                    input logic [1:0] p = 2'h0);
    mw(MREG_LO, d[15:0], p);
    mw(MREG_HI, d[31:16], p);
    mw(MREG_CMD, {13'h0000, i} | 16'h8000, p);
  endtask : tw
  task automatic tr(input logic [2:0] i, output logic [31:0] d,
                    input logic [1:0] p = 2'h0);
    mw(MREG_CMD, {13'h0000, i} | 16'hC000, p);
    mr(MREG_LO, d[15:0]);
    mr(MREG_HI, d[31:16]);
  endtask : tr
  task automatic lv(input logic l, output int c);
    c = 0;
    while (pps_o !== l && c < 400)
    begin
      @(posedge clk_i);
      #1 c++;
    end
  endtask : lv
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_window();
    logic [15:0] d;
    mw(MREG_LO, 16'h1234);
    mr(MREG_LO, d);
    `CHK("reg17 off page", 16'h0000, d)
    mw(MREG_PAGE, PAGE_TIMING);
    tr(TR_WIDTH, v);
    `CHK("width reset", WIDTH_RST, v)
    tw(TR_HIRES, 32'h0000_0015);
    tr(TR_HIRES, v);
    `CHK("hires read", 32'h0000_0015, v)
    `CHK("hires", 5'h15, hires_en_o)
    mw(MREG_EXT30, EXT_KEY30);
    mw(MREG_EXT29, EXT_KEY29);
    repeat (3) @(posedge clk_i);
    `CHK("ext on", 1'b1, ext_clk_sel_o)
    mw(MREG_EXT30, 16'h0000);
    repeat (3) @(posedge clk_i);
    `CHK("ext off", 1'b0, ext_clk_sel_o)
  endtask : t_window
  task automatic t_engines();
    eng_b_rdata_i <= 32'hA5A5_5A5A;
    tr(TR_CTRL, v, 2'h1);
    `CHK("engine b read", 32'hA5A5_5A5A, v)
    tw(TR_SYN_LO, 32'h1234_5678, 2'h3);
    repeat (2) @(posedge clk_i);
    `CHK("engine b write", {1'b1, TR_SYN_LO, 32'h1234_5678}, last_b)
    // Far threshold, so no stray pulse of reset width
    tw(TR_THRESH, 32'h3B00_0000, 2'h2);
    tr(TR_THRESH, v);
    `CHK("engine a", 32'h3B00_0000, v)
  endtask : t_engines
  task automatic t_rate();
    int st[4] = '{80, 64, 50, 40};
    logic [NS_W-1:0] d;
    for (int r = 0; r < 4; r++)
    begin
      @(posedge clk_i);
      ltc_rate_i <= 2'(r);
      repeat (3) @(posedge clk_i);
      t0 = ltc_ns_o;
      repeat (10) @(posedge clk_i);
      d = ltc_ns_o - t0;
      // Fractional rate may land one short
      if (r == 1 && d == 30'h3F)
        d = 30'h40;
      `CHK("ns step", 30'(st[r]), d)
    end
    ltc_rate_i <= 2'h0;
  endtask : t_rate
  task automatic t_pulse();
    tw(TR_WIDTH, 32'h0000_00C8);
    tw(TR_CTRL, 32'h0000_0040);
    t0 = ltc_ns_o + 30'h320;
    tw(TR_THRESH, {2'b00, t0});
    oe_lo = 0;
    m = rises;
    lv(1'b1, n);
    `CHK("cross", 1'b1, ltc_ns_o >= t0 && ltc_ns_o <= t0 + 30'h20)
    `CHK("pin driven", 1'b1, strobe_i)
    lv(1'b0, n);
    `CHK("width", 1'b1, n >= 24 && n <= 26)
    `CHK("oe early", 1'b1, oe_pre)
    `CHK("oe cycles", 3, oe_lo)
    `CHK("far end", 8'(m + 1), rises)
  endtask : t_pulse
  task automatic t_alt_synth();
    for (int s = 0; s < 5; s++)
    begin
      tw(TR_CTRL, 32'(1 + 2 * s));
      // New bit reaches the pin late, first phase may be partial
      repeat (3) @(posedge clk_i);
      lv(1'b1, n);
      lv(1'b0, n);
      lv(1'b1, m);
      lv(1'b0, n);
      `CHK("alt high", 2 << s, n)
      `CHK("alt period", 4 << s, n + m)
    end
    tw(TR_SYN_HI, 32'h0000_0028); // Whole clock periods
    tw(TR_SYN_LO, 32'h0000_0050);
    tw(TR_CTRL, 32'h0000_0010);
    lv(1'b0, n);
    lv(1'b1, n);
    lv(1'b0, n);
    lv(1'b1, m);
    `CHK("synth high", 5, n)
    `CHK("synth low", 10, m)
    tw(TR_CTRL, 32'h0000_0000);
    n = 0;
    repeat (40)
    begin
      @(posedge clk_i);
      #1 n += (pps_o !== 1'b0);
    end
    `CHK("synth off", 0, n)
    tw(TR_CTRL, 32'h0000_0020);
    lvl <= 1'b1;
    @(posedge clk_i);
    #1 `CHK("loop high", 1'b1, pps_o)
    @(posedge clk_i);
    lvl <= 1'b0;
    #1 `CHK("loop low", 1'b0, pps_o)
  endtask : t_alt_synth
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    rst_n_i = 1'b0;
    ltc_rate_i = 2'h0;
    mgmt_we_i = 1'b0;
    mgmt_addr_i = 5'h00;
    mgmt_wdata_i = 16'h0000;
    mgmt_port_i = 2'h0;
    eng_b_rdata_i = 32'h0000_0000;
    lvl = 1'b0;
    repeat (5) @(posedge clk_i);
    #1 `CHK("pps reset", 1'b0, pps_o)
    `CHK("sec reset", 48'h0000_0000_0000, ltc_sec_o)
    `CHK("oe reset", 1'b1, strobe_oe_n_o)
    `CHK("hires reset", 5'h00, hires_en_o)
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_window();
    t_engines();
    t_rate();
    t_pulse();
    t_alt_synth();
    wrap_up();
  end
endmodule : tpo_gen_bench

// ---- tpo_gen_props.sv ----
// Purpose: Port-level checks of the pulse output generator
// Assumes: Pulse-to-strobe loop stays off, so sync path is raw pin
// Notes: Counter step checked only at exact-step clock rates
module tpo_gen_props
  import tpo_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic [1:0] ltc_rate_i,
  input wire logic mgmt_we_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic [1:0] mgmt_port_i,
  input wire logic eng_b_valid_o,
  input wire logic eng_b_write_o,
  input wire logic [2:0] eng_b_idx_o,
  input wire logic pps_o,
  input wire logic gpio_pps_o,
  input wire logic strobe_i,
  input wire logic strobe_out_o,
  input wire logic strobe_oe_n_o,
  input wire logic strobe_sync_o,
  input wire logic [NS_W-1:0] ltc_ns_o,
  input wire logic ext_clk_sel_o
);
  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [NS_W-1:0] step;
  assign step = (ltc_rate_i == RATE_125) ? 30'h8 :
                (ltc_rate_i == RATE_200) ? 30'h5 : 30'h4;

  a_pin_before_pulse: assert property (
    $fell(strobe_oe_n_o) |=> pps_o && strobe_out_o)
    else $error("strobe pin enabled without a following pulse");
  a_pin_three_cyc: assert property (
    $fell(strobe_oe_n_o) |-> !strobe_oe_n_o [*3] ##1 strobe_oe_n_o)
    else $error("strobe pin enable not held three cycles");
  a_gpio_copy: assert property (gpio_pps_o == pps_o)
    else $error("pulse not routed to general-purpose pin");
  // Three stable samples cover any rate pipeline before the output
  a_ns_step: assert property (
    ltc_rate_i != RATE_156 && $past(ltc_rate_i) == ltc_rate_i &&
    $past(ltc_rate_i, 2) == ltc_rate_i &&
    $past(ltc_rate_i, 3) == ltc_rate_i && $past(ltc_ns_o) != 30'h0
    |-> ltc_ns_o == $past(ltc_ns_o) + step)
    else $error("nanosecond counter step wrong for clock rate");
  a_engb_single: assert property (eng_b_valid_o |=> !eng_b_valid_o)
    else $error("engine b command longer than one cycle");
  a_engb_cause: assert property (
    $rose(eng_b_valid_o) |-> $past(mgmt_we_i) && $past(mgmt_port_i[0])
    && $past(mgmt_addr_i) == MREG_CMD)
    else $error("engine b command without odd-port command write");
  a_engb_kind: assert property (
    eng_b_valid_o |-> eng_b_idx_o == $past(mgmt_wdata_i[2:0]) &&
    eng_b_write_o == !$past(mgmt_wdata_i[CMD_RD]))
    else $error("engine b index or direction differs from command");
  a_sync_two: assert property (
    $past(rst_n_i) && $past(rst_n_i, 2)
    |-> strobe_sync_o == $past(strobe_i, 2))
    else $error("strobe input path not two flops deep");
  a_ext_cause: assert property (
    $rose(ext_clk_sel_o) |-> $past(mgmt_we_i) || $past(mgmt_we_i, 2))
    else $error("clock select changed without a key write");

  c_pulse: cover property ($rose(pps_o));
  c_pin: cover property ($fell(strobe_oe_n_o));
  c_engb: cover property (eng_b_valid_o);
  c_ext: cover property ($rose(ext_clk_sel_o));
endmodule : tpo_gen_props

bind tpo_gen tpo_gen_props u_props (
  .clk_i, .rst_n_i, .ltc_rate_i, .mgmt_we_i, .mgmt_addr_i,
  .mgmt_wdata_i, .mgmt_port_i, .eng_b_valid_o, .eng_b_write_o,
  .eng_b_idx_o, .pps_o, .gpio_pps_o, .strobe_i, .strobe_out_o,
  .strobe_oe_n_o, .strobe_sync_o, .ltc_ns_o, .ext_clk_sel_o
);

// ---- tpo_mgmt_if.sv ----
// Purpose: Timing register command path from window to engine
// Assumes: Read data answers in the cycle of the request
// Notes: One-cycle valid per command
interface tpo_mgmt_if;
  logic valid;
  logic write;
  logic eng_b;
  logic [2:0] idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport win (output valid, write, eng_b, idx, wdata, input rdata);
  modport eng (input valid, write, eng_b, idx, wdata, output rdata);
endinterface : tpo_mgmt_if

// ---- tpo_pkg.sv ----
// Purpose: Shared constants and types of the time pulse output generator
// Assumes: Counter clock is one of four supported rates
// Notes: Nanosecond values carry FRAC_W fractional bits internally
package tpo_pkg;

  // ==========================================================
  // Counter widths and fixed point
  // ==========================================================
  localparam int NS_W = 30;
  localparam int SEC_W = 48;
  localparam int FRAC_W = 8;
  localparam int FX_W = NS_W + FRAC_W;
  localparam int INC_W = 12;
  localparam logic [FX_W-1:0] NS_WRAP_FX = 38'h3B_9ACA_0000;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 8'h00;
  // Per-cycle increments, 8 fractional bits
  localparam logic [INC_W-1:0] INC_125 = 12'h800;
  localparam logic [INC_W-1:0] INC_156 = 12'h666;
  localparam logic [INC_W-1:0] INC_200 = 12'h500;
  localparam logic [INC_W-1:0] INC_250 = 12'h400;
  localparam logic [1:0] RATE_125 = 2'h0;
  localparam logic [1:0] RATE_156 = 2'h1;
  localparam logic [1:0] RATE_200 = 2'h2;

  // ==========================================================
  // Alternate mode and strobe pin drive
  // ==========================================================
  localparam int ALT_BIT_BASE = 4;
  localparam logic [2:0] ALT_SEL_MAX = 3'h4;
  localparam logic [1:0] STROBE_OE_LEN = 2'h3;

  // ==========================================================
  // Management window
  // ==========================================================
  localparam logic [4:0] MREG_CMD = 5'h10;
  localparam logic [4:0] MREG_LO = 5'h11;
  localparam logic [4:0] MREG_HI = 5'h12;
  localparam logic [4:0] MREG_EXT29 = 5'h1D;
  localparam logic [4:0] MREG_EXT30 = 5'h1E;
  localparam logic [4:0] MREG_PAGE = 5'h1F;
  localparam logic [15:0] PAGE_TIMING = 16'h0004;
  localparam logic [15:0] EXT_KEY29 = 16'h7AE0;
  localparam logic [15:0] EXT_KEY30 = 16'hB71C;
  localparam int CMD_GO = 15;
  localparam int CMD_RD = 14;

  // ==========================================================
  // Timing register indices and control bits
  // ==========================================================
  localparam logic [2:0] TR_THRESH = 3'h0;
  localparam logic [2:0] TR_WIDTH = 3'h1;
  localparam logic [2:0] TR_CTRL = 3'h2;
  localparam logic [2:0] TR_SYN_HI = 3'h3;
  localparam logic [2:0] TR_SYN_LO = 3'h4;
  localparam logic [2:0] TR_HIRES = 3'h5;
  localparam logic [2:0] TR_NS = 3'h6;
  localparam logic [2:0] TR_SEC = 3'h7;
  localparam int CB_ALT_EN = 0;
  localparam int CB_ALT_SEL = 1;
  localparam int CB_SYN_EN = 4;
  localparam int CB_S2P = 5;
  localparam int CB_PIN = 6;
  localparam int CB_P2S = 7;
  localparam logic [31:0] THRESH_RST = 32'h0000_0000;
  localparam logic [31:0] WIDTH_RST = 32'h05F5_E100;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] SYN_RST = 32'h0000_0032;
  localparam logic [4:0] HIRES_RST = 5'h00;

  typedef enum logic [2:0] {
    TPO_IDLE = 3'b001,
    TPO_ARMED = 3'b010,
    TPO_HIGH = 3'b100
  } tpo_pstate_t;

endpackage : tpo_pkg

// ---- tpo_synth.sv ----
// Purpose: Toggle synthesizer with programmable high and low times
// Assumes: Durations in ns, increment in fixed point
// Notes: Excess time carried over, so error does not accumulate
module tpo_synth
  import tpo_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic en_i,
  input wire logic [INC_W-1:0] inc_i,
  input wire logic [31:0] hi_ns_i,
  input wire logic [31:0] lo_ns_i,
  // Output
  output logic out_o
);
  typedef struct packed {
    logic lvl;
    logic [39:0] acc;
  } tpo_syn_t;
  tpo_syn_t s_r;
  tpo_syn_t s_nxt;
  logic [39:0] acc_n;
  logic [39:0] dur;

  always_comb
  begin
    s_nxt = s_r;
    acc_n = s_r.acc + {28'h000_0000, inc_i};
    dur = {s_r.lvl ? hi_ns_i : lo_ns_i, FRAC_ZERO};
    if (!en_i)
    begin
      s_nxt = '0;
    end
    else if (acc_n >= dur)
    begin
      s_nxt.lvl = ~s_r.lvl;
      s_nxt.acc = acc_n - dur;
    end
    else
    begin
      s_nxt.acc = acc_n;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign out_o = s_r.lvl;
endmodule : tpo_synth

// ---- tpo_window.sv ----
// Purpose: Paged management window onto the 32-bit timing registers
// Assumes: One management write per cycle
// Notes: Read data is registered, one cycle after address
module tpo_window
  import tpo_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Management access
  input wire logic mgmt_we_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic [1:0] mgmt_port_i,
  output logic [15:0] mgmt_rdata_o,
  output logic ext_clk_sel_o,
  // Command path
  tpo_mgmt_if.win m
);
  typedef struct packed {
    logic [15:0] page;
    logic [15:0] cmd;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] ext29;
    logic [15:0] ext30;
    logic valid;
    logic write;
    logic eng_b;
    logic [2:0] idx;
    logic [15:0] rd;
  } tpo_win_t;
  tpo_win_t s_r;
  tpo_win_t s_nxt;
  logic on_page;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    on_page = (s_r.page == PAGE_TIMING);
    if (s_r.valid)
    begin
      s_nxt.cmd[CMD_GO] = 1'b0;
      if (!s_r.write)
      begin
        s_nxt.hi = m.rdata[31:16];
        s_nxt.lo = m.rdata[15:0];
      end
    end
    if (mgmt_we_i)
    begin
      if (mgmt_addr_i == MREG_PAGE)
        s_nxt.page = mgmt_wdata_i;
      else if (on_page)
      begin
        unique case (mgmt_addr_i)
          MREG_CMD:
          begin
            s_nxt.cmd = mgmt_wdata_i;
            s_nxt.valid = mgmt_wdata_i[CMD_GO];
            s_nxt.write = ~mgmt_wdata_i[CMD_RD];
            s_nxt.idx = mgmt_wdata_i[2:0];
            s_nxt.eng_b = mgmt_port_i[0];
          end
          MREG_LO: s_nxt.lo = mgmt_wdata_i;
          MREG_HI: s_nxt.hi = mgmt_wdata_i;
          MREG_EXT29: s_nxt.ext29 = mgmt_wdata_i;
          MREG_EXT30: s_nxt.ext30 = mgmt_wdata_i;
          default: ;
        endcase
      end
    end
    s_nxt.rd = 16'h0000;
    if (mgmt_addr_i == MREG_PAGE)
      s_nxt.rd = s_r.page;
    else if (on_page)
    begin
      unique case (mgmt_addr_i)
        MREG_CMD: s_nxt.rd = s_r.cmd;
        MREG_LO: s_nxt.rd = s_r.lo;
        MREG_HI: s_nxt.rd = s_r.hi;
        MREG_EXT29: s_nxt.rd = s_r.ext29;
        MREG_EXT30: s_nxt.rd = s_r.ext30;
        default: s_nxt.rd = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign m.valid = s_r.valid;
  assign m.write = s_r.write;
  assign m.eng_b = s_r.eng_b;
  assign m.idx = s_r.idx;
  assign m.wdata = {s_r.hi, s_r.lo};
  assign mgmt_rdata_o = s_r.rd;
  // Both keys must match, any other pattern keeps internal clock
  assign ext_clk_sel_o = (s_r.ext30 == EXT_KEY30) &&
                         (s_r.ext29 == EXT_KEY29);
endmodule : tpo_window
